// [logic/bwcr_pkg.sv]
// Constants for the bridge window configuration bank: offsets, field layouts, reset values.
// Assumes byte-addressed configuration offsets whose bits [1:0] are ignored by the bank.
package bwcr_pkg;
  localparam logic [11:0] OFS_PREF_LIMIT_HI = 12'h02C;
  localparam logic [11:0] OFS_IO_HI = 12'h030;
  localparam logic [11:0] OFS_CAP_PTR = 12'h034;
  localparam logic [11:0] OFS_IRQ = 12'h03C;
  localparam int IO_BASE_LSB = 0;
  localparam int IO_LIMIT_LSB = 16;
  localparam int IRQ_LINE_LSB = 0;
  localparam int IRQ_PIN_LSB = 8;
  localparam logic [31:0] RST_PREF_LIMIT_HI = 32'h0000_0000;
  localparam logic [15:0] RST_IO_HALF = 16'h0000;
  localparam logic [7:0] RST_IRQ_LINE = 8'h00;
  localparam logic [7:0] RST_IRQ_PIN = 8'h00;
  localparam logic [7:0] CAP_PTR_VALUE = 8'h40;
  localparam logic [19:0] PREF_LIMIT_ONES = 20'hFFFFF;
  localparam logic [11:0] IO_LIMIT_ONES = 12'hFFF;
  localparam logic [11:0] IO_BASE_ZEROS = 12'h000;
endpackage

// [logic/bwcr_window_match.sv]
// Inclusive address window comparator with a registered hit flag.
// Assumes base, limit and address come from logic on the same clock.
`timescale 1ns/1ps
module bwcr_window_match #(
  parameter int W = 32
) (
  input wire logic clk_sys_i, // Core clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic ce_i, // Clock enable
  input wire logic valid_i, // Address is presented
  input wire logic [W-1:0] addr_i, // Transaction address
  input wire logic [W-1:0] base_i, // Lower bound, inclusive
  input wire logic [W-1:0] limit_i, // Upper bound, inclusive
  output logic hit_o // Forward across the bridge
);
  typedef struct packed {
    logic hit;
  } bwcr_match_s;

  bwcr_match_s state;
  bwcr_match_s next_state;

  // A zero-width comparator has nothing to compare, refused at elaboration
  if (W < 1)
  begin
    $error("bwcr_window_match: W must be at least 1");
  end

  // Base above limit yields an empty window, no hit
  always_comb
  begin
    next_state = state;
    next_state.hit = valid_i && (addr_i >= base_i) && (addr_i <= limit_i);
  end

  // Registered hit keeps the routing decision glitch free
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state <= '0;
    else if (ce_i)
      state <= next_state;
  end

  assign hit_o = state.hit;

  window_hit_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i |=> hit_o == ($past(valid_i) && $past(addr_i) >= $past(base_i) && $past(addr_i) <= $past(limit_i)))
    else $error("window hit disagrees with bounds");
endmodule

// [logic/bwcr_regs.sv]
// Bridge window configuration bank: upper address halves, capability pointer, interrupt fields.
// Assumes configuration requests, the lower window fields and sideband loads all arrive on clk_sys_i.
`timescale 1ns/1ps
module bwcr_regs #(
  parameter int CFG_AW = 12
) (
  input wire logic clk_sys_i, // Core clock, 100 MHz
  input wire logic rstn_i, // Async reset, active low
  input wire logic ce_i, // Clock enable, freezes all state
  input wire logic cfg_wr_i, // Configuration write strobe
  input wire logic cfg_rd_i, // Configuration read strobe
  input wire logic [CFG_AW-1:0] cfg_addr_i, // Byte offset of the word
  input wire logic [3:0] cfg_be_i, // Write byte enables
  input wire logic [31:0] cfg_wdata_i, // Write data
  output logic [31:0] cfg_rdata_o, // Read data, registered
  output logic cfg_ack_o, // Read data valid, one cycle
  input wire logic irq_pin_load_i, // Sideband or EEPROM override strobe
  input wire logic [7:0] irq_pin_value_i, // Override value for the pin field
  input wire logic [11:0] pref_limit_low_i, // Prefetchable limit bits 31:20
  input wire logic [63:0] pref_base_i, // Assembled prefetchable base
  input wire logic [3:0] io_base_low_i, // I/O base bits 15:12
  input wire logic [3:0] io_limit_low_i, // I/O limit bits 15:12
  input wire logic mem_valid_i, // Memory address presented
  input wire logic [63:0] mem_addr_i, // Memory transaction address
  input wire logic io_valid_i, // I/O address presented
  input wire logic [31:0] io_addr_i, // I/O transaction address
  output logic [63:0] pref_limit_o, // Assembled prefetchable upper bound
  output logic [31:0] io_base_o, // Assembled I/O lower bound
  output logic [31:0] io_limit_o, // Assembled I/O upper bound
  output logic [7:0] irq_line_o, // Interrupt line value
  output logic [7:0] irq_pin_o, // Interrupt pin value
  output logic mem_hit_o, // Memory address inside window
  output logic io_hit_o // I/O address inside window
);
  typedef struct packed {
    logic [31:0] pml_hi;
    logic [15:0] io_base_hi;
    logic [15:0] io_limit_hi;
    logic [7:0] irq_line;
    logic [7:0] irq_pin;
    logic [31:0] rdata;
    logic ack;
    logic [63:0] pref_limit;
    logic [31:0] io_base;
    logic [31:0] io_limit;
  } bwcr_state_s;

  localparam bwcr_state_s RST_STATE = '{
    pml_hi: bwcr_pkg::RST_PREF_LIMIT_HI,
    io_base_hi: bwcr_pkg::RST_IO_HALF,
    io_limit_hi: bwcr_pkg::RST_IO_HALF,
    irq_line: bwcr_pkg::RST_IRQ_LINE,
    irq_pin: bwcr_pkg::RST_IRQ_PIN,
    rdata: 32'h0000_0000,
    ack: 1'b0,
    pref_limit: 64'h0000_0000_0000_0000,
    io_base: 32'h0000_0000,
    io_limit: 32'h0000_0000
  };

  bwcr_state_s state;
  bwcr_state_s next_state;
  logic [11:0] word_ofs;

  // Too few bits cannot reach 0x3C, more than 12 would not fit the offset compare
  if (CFG_AW < 6 || CFG_AW > 12)
  begin
    $error("bwcr_regs: CFG_AW must lie in 6..12");
  end

  // Byte-lane merge shared by every writable word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[i*8 +: 8] = wd[i*8 +: 8];
    end
    return res;
  endfunction

  // Low two address bits ignored, accesses are whole aligned words
  assign word_ofs = 12'({cfg_addr_i[CFG_AW-1:2], 2'b00});

  // Write decode, read mux and window assembly
  always_comb
  begin
    logic [31:0] merged;
    merged = 32'h0000_0000;
    next_state = state;
    next_state.ack = cfg_rd_i;
    if (cfg_wr_i)
    begin
      unique case (word_ofs)
        bwcr_pkg::OFS_PREF_LIMIT_HI:
        begin
          next_state.pml_hi = be_merge(state.pml_hi, cfg_wdata_i, cfg_be_i);
        end
        bwcr_pkg::OFS_IO_HI:
        begin
          merged = be_merge({state.io_limit_hi, state.io_base_hi}, cfg_wdata_i, cfg_be_i);
          next_state.io_base_hi = merged[bwcr_pkg::IO_BASE_LSB +: 16];
          next_state.io_limit_hi = merged[bwcr_pkg::IO_LIMIT_LSB +: 16];
        end
        bwcr_pkg::OFS_IRQ:
        begin
          // Only the line byte is writable; pin byte ignores configuration writes
          merged = be_merge({24'h000000, state.irq_line}, cfg_wdata_i, cfg_be_i);
          next_state.irq_line = merged[bwcr_pkg::IRQ_LINE_LSB +: 8];
        end
        default:
        begin
          next_state.pml_hi = state.pml_hi;
        end
      endcase
    end
    // Sideband load changes the advertised pin, writes from the host cannot
    if (irq_pin_load_i)
      next_state.irq_pin = irq_pin_value_i;
    if (cfg_rd_i)
    begin
      unique case (word_ofs)
        bwcr_pkg::OFS_PREF_LIMIT_HI: next_state.rdata = state.pml_hi;
        bwcr_pkg::OFS_IO_HI: next_state.rdata = {state.io_limit_hi, state.io_base_hi};
        bwcr_pkg::OFS_CAP_PTR: next_state.rdata = {24'h000000, bwcr_pkg::CAP_PTR_VALUE};
        bwcr_pkg::OFS_IRQ: next_state.rdata = {16'h0000, state.irq_pin, state.irq_line};
        default: next_state.rdata = 32'h0000_0000;
      endcase
    end
    // Bounds use the current fields; a write shows up one cycle later
    next_state.pref_limit = {state.pml_hi, pref_limit_low_i, bwcr_pkg::PREF_LIMIT_ONES};
    next_state.io_base = {state.io_base_hi, io_base_low_i, bwcr_pkg::IO_BASE_ZEROS};
    next_state.io_limit = {state.io_limit_hi, io_limit_low_i, bwcr_pkg::IO_LIMIT_ONES};
  end

  // Single state register, frozen while the clock enable is low
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state <= RST_STATE;
    else if (ce_i)
      state <= next_state;
  end

  assign cfg_rdata_o = state.rdata;
  assign cfg_ack_o = state.ack;
  assign pref_limit_o = state.pref_limit;
  assign io_base_o = state.io_base;
  assign io_limit_o = state.io_limit;
  assign irq_line_o = state.irq_line;
  assign irq_pin_o = state.irq_pin;

  // Routing compare for the prefetchable memory window
  bwcr_window_match #(
    .W(64)
  ) u_mem_match (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .valid_i(mem_valid_i),
    .addr_i(mem_addr_i),
    .base_i(pref_base_i),
    .limit_i(state.pref_limit),
    .hit_o(mem_hit_o)
  );

  // Routing compare for the I/O window
  bwcr_window_match #(
    .W(32)
  ) u_io_match (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .valid_i(io_valid_i),
    .addr_i(io_addr_i),
    .base_i(state.io_base),
    .limit_i(state.io_limit),
    .hit_o(io_hit_o)
  );

  // Checks beside the logic
  sequence pin_write_s;
    ce_i && cfg_wr_i && word_ofs == bwcr_pkg::OFS_IRQ && !irq_pin_load_i;
  endsequence

  sequence irq_read_s;
    ce_i && cfg_rd_i && word_ofs == bwcr_pkg::OFS_IRQ;
  endsequence

  pref_hi_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && cfg_rd_i && word_ofs == bwcr_pkg::OFS_PREF_LIMIT_HI
    |=> cfg_ack_o && cfg_rdata_o == $past(state.pml_hi))
    else $error("prefetch limit high word read wrong");
  io_hi_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && cfg_rd_i && word_ofs == bwcr_pkg::OFS_IO_HI
    |=> cfg_rdata_o[15:0] == $past(state.io_base_hi) && cfg_rdata_o[31:16] == $past(state.io_limit_hi))
    else $error("io window halves read wrong");
  pin_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    irq_read_s |=> cfg_ack_o && cfg_rdata_o == {16'h0000, $past(irq_pin_o), $past(irq_line_o)})
    else $error("interrupt word read wrong");

  pref_hi_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && cfg_wr_i && word_ofs == bwcr_pkg::OFS_PREF_LIMIT_HI && cfg_be_i == 4'hF |=> state.pml_hi == $past(cfg_wdata_i))
    else $error("prefetch limit high word not written");
  io_base_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && cfg_wr_i && word_ofs == bwcr_pkg::OFS_IO_HI && cfg_be_i == 4'h3
    |=> state.io_base_hi == $past(cfg_wdata_i[15:0]) && $stable(state.io_limit_hi))
    else $error("io base half not written alone");
  io_limit_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && cfg_wr_i && word_ofs == bwcr_pkg::OFS_IO_HI && cfg_be_i == 4'hC
    |=> state.io_limit_hi == $past(cfg_wdata_i[31:16]) && $stable(state.io_base_hi))
    else $error("io limit half not written alone");
  cap_ptr_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && cfg_rd_i && word_ofs == bwcr_pkg::OFS_CAP_PTR |=> cfg_ack_o && cfg_rdata_o == 32'h0000_0040)
    else $error("capability pointer read wrong");
  pin_read_only_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    pin_write_s |=> $stable(irq_pin_o))
    else $error("interrupt pin changed by config write");
  pin_override_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && irq_pin_load_i |=> irq_pin_o == $past(irq_pin_value_i)
    ##1 (!$past(ce_i) || $past(irq_pin_load_i) || $stable(irq_pin_o)))
    else $error("interrupt pin override not held");
  pref_limit_form_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i |=> pref_limit_o[19:0] == 20'hFFFFF && pref_limit_o[31:20] == $past(pref_limit_low_i))
    else $error("prefetch upper bound badly formed");
  io_bound_form_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i |=> io_limit_o == {$past(state.io_limit_hi), $past(io_limit_low_i), 12'hFFF}
    && io_base_o[11:0] == 12'h000)
    else $error("io bounds badly formed");
endmodule

// [verification/bwcr_host_model.sv]
// Host model issuing configuration reads and writes to the bank.
// Assumes the bank takes requests on the rising edge; this model changes lines on the falling edge.
`timescale 1ns/1ps
module bwcr_host_model (
  input wire logic clk_sys_i, // Core clock
  output logic cfg_wr_o, // Write strobe
  output logic cfg_rd_o, // Read strobe
  output logic [11:0] cfg_addr_o, // Byte offset
  output logic [3:0] cfg_be_o, // Byte enables
  output logic [31:0] cfg_wdata_o // Write data
);
  // Idle from time zero
  initial
  begin
    cfg_wr_o = 1'b0;
    cfg_rd_o = 1'b0;
    cfg_addr_o = 12'hFFF;
    cfg_be_o = 4'hF;
    cfg_wdata_o = 32'hFFFFFFFF;
  end
  // One-cycle strobe; released lines show the inverse so stale values never pass
  task automatic access(input logic wr, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk_sys_i);
    cfg_wr_o <= wr;
    cfg_rd_o <= ~wr;
    cfg_addr_o <= a;
    cfg_be_o <= be;
    cfg_wdata_o <= d;
    @(negedge clk_sys_i);
    cfg_wr_o <= 1'b0;
    cfg_rd_o <= 1'b0;
    cfg_addr_o <= ~a;
    cfg_be_o <= ~be;
    cfg_wdata_o <= ~d;
  endtask
endmodule

// [verification/bwcr_regs_tb.sv]
// Self-checking bench for the bridge window configuration bank.
// Assumes the host model drives the config port; this bench drives sideband and routing inputs.
`timescale 1ns/1ps
module bwcr_regs_tb;
  logic clk_sys_i, rstn_i, ce, cfg_wr, cfg_rd, cfg_ack, pin_ld, mem_v, io_v, mem_hit, io_hit;
  logic [11:0] addr, pl_low;
  logic [3:0] be, iob_l, iol_l;
  logic [31:0] wd, rdat, io_a, io_b, io_l, r, ph;
  logic [15:0] b, l;
  logic [7:0] pin_v, line, pin;
  logic [63:0] pbase, mem_a, plim;
  logic [31:0] exp_q[$];
  int num_errors, n_checks;
  bwcr_regs bwcr_regs_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce), .cfg_wr_i(cfg_wr),
    .cfg_rd_i(cfg_rd), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_rdata_o(rdat),
    .cfg_ack_o(cfg_ack), .irq_pin_load_i(pin_ld), .irq_pin_value_i(pin_v), .pref_limit_low_i(pl_low),
    .pref_base_i(pbase), .io_base_low_i(iob_l), .io_limit_low_i(iol_l), .mem_valid_i(mem_v),
    .mem_addr_i(mem_a), .io_valid_i(io_v), .io_addr_i(io_a), .pref_limit_o(plim), .io_base_o(io_b),
    .io_limit_o(io_l), .irq_line_o(line), .irq_pin_o(pin), .mem_hit_o(mem_hit), .io_hit_o(io_hit));
  bwcr_host_model bwcr_host_model_inst (.clk_sys_i(clk_sys_i), .cfg_wr_o(cfg_wr), .cfg_rd_o(cfg_rd),
    .cfg_addr_o(addr), .cfg_be_o(be), .cfg_wdata_o(wd));
  // Free-running 100 MHz clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t read got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_out(input logic [63:0] g, input logic [63:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t output got %h exp %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Expected read data is noted before the request goes out
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bwcr_host_model_inst.access(1'b0, a, 4'h0, 32'h00000000);
  endtask
  task automatic wr(input logic [11:0] a, input logic [3:0] m, input logic [31:0] d);
    bwcr_host_model_inst.access(1'b1, a, m, d);
  endtask
  // Walk just below, at, and just above each bound
  task automatic win(input logic io, input logic [63:0] lo, input logic [63:0] hi);
    for (int i = 0; i < 4; i++)
    begin
      mem_a = (i < 2) ? lo - 64'h1 + 64'(i) : hi + 64'(i) - 64'h2;
      io_a = mem_a[31:0];
      mem_v = ~io;
      io_v = io;
      repeat (2) @(negedge clk_sys_i);
      cmp_out({63'h0, io ? io_hit : mem_hit}, {63'h0, i == 1 || i == 2});
    end
    mem_v = 1'b0;
    io_v = 1'b0;
  endtask
  // Read results are taken off the queue when the answer appears; empty queue forces a mismatch
  always @(negedge clk_sys_i)
    if (cfg_ack === 1'b1)
      cmp_rd(rdat, exp_q.size() ? exp_q.pop_front() : {32{rdat === 32'h00000000}});
  initial
  begin
    {rstn_i, pin_ld, mem_v, io_v, pin_v, pl_low, iob_l, iol_l} = '0;
    {pbase, mem_a, io_a, num_errors, n_checks} = '0;
    r = 32'hDC7742CB;
    ce = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    // Reset values and an unmapped offset
    rd(12'h02C, 32'h00000000);
    rd(12'h030, 32'h00000000);
    rd(12'h034, 32'h00000040);
    rd(12'h03C, 32'h00000000);
    rd(12'h038, 32'h00000000);
    r = lfsr(r);
    ph = r;
    wr(12'h02C, 4'hF, ph);
    rd(12'h02C, ph);
    // Write under a low clock enable is lost; idle cycle first, else the last ack would be frozen high
    @(negedge clk_sys_i);
    ce = 1'b0;
    wr(12'h02C, 4'hF, ~ph);
    ce = 1'b1;
    rd(12'h02C, ph);
    // Each half of 0x30 written alone by its byte enables
    r = lfsr(r);
    // Top bit cleared so limit = base + 1 cannot wrap below the base
    b = (r[15:0] & 16'h7FFF) | 16'h0100;
    l = b + 16'h0001;
    wr(12'h030, 4'h3, {16'h5A5A, b});
    rd(12'h030, {16'h0000, b});
    wr(12'h030, 4'hC, {l, 16'hA5A5});
    rd(12'h030, {l, b});
    // Read-only places ignore writes
    wr(12'h034, 4'hF, 32'hFFFFFFFF);
    rd(12'h034, 32'h00000040);
    wr(12'h03C, 4'hF, 32'hFFFFFFFF);
    rd(12'h03C, 32'h000000FF);
    cmp_out({48'h0, pin, line}, 64'h0000_0000_0000_00FF);
    // Override load is the only way into the pin field
    r = lfsr(r);
    pin_v = r[7:0];
    pin_ld = 1'b1;
    @(negedge clk_sys_i);
    pin_ld = 1'b0;
    cmp_out({56'h0, pin}, {56'h0, pin_v});
    rd(12'h03C, {16'h0000, pin_v, 8'hFF});
    // Assembled bounds and window decisions
    {pl_low, iob_l, iol_l} = r[31:12];
    pbase = {ph, 32'h00000000};
    repeat (3) @(negedge clk_sys_i);
    cmp_out(plim, {ph, pl_low, 20'hFFFFF});
    cmp_out({32'h0, io_b}, {32'h0, b, iob_l, 12'h000});
    cmp_out({32'h0, io_l}, {32'h0, l, iol_l, 12'hFFF});
    win(1'b1, {32'h0, b, iob_l, 12'h000}, {32'h0, l, iol_l, 12'hFFF});
    win(1'b0, pbase, {ph, pl_low, 20'hFFFFF});
    // Second reset in mid-run clears the fields again
    rstn_i = 1'b0;
    @(negedge clk_sys_i);
    rstn_i = 1'b1;
    cmp_out({56'h0, pin}, 64'h0);
    rd(12'h02C, 32'h00000000);
    rd(12'h030, 32'h00000000);
    repeat (3) @(negedge clk_sys_i);
    if (exp_q.size() != 0)
      num_errors++;
    report_and_stop();
  end
endmodule
